// file: pkg/dct_pkg.sv
// Purpose: constants for demodulator config and test-mode control
// Assumes: serial words arrive as 8-bit frames after an interface reset
// Notes:   config page write = 2'b01 prefix, 2-bit page, 4 data bits
package dct_pkg;
  localparam logic [1:0] CMD_PAGE_PREFIX  = 2'h1;
  localparam logic [7:0] CMD_ANALOG_TEST_OUTPUT_COMMAND  = 8'h21;
  localparam logic [7:0] CMD_TEST_OFF     = 8'h10;
  localparam int         PAGE_HI          = 5;
  localparam int         PAGE_LO          = 4;
  localparam logic [1:0] PAGE_GAIN_FILT   = 2'h0;
  localparam logic [1:0] PAGE_HYST        = 2'h1;
  localparam logic [1:0] PAGE_ACQ         = 2'h2;
  localparam logic [1:0] PAGE_LP_BYPASS   = 2'h3;
  localparam int         BIT_FILTER_LOW   = 0;
  localparam int         BIT_FILTER_HIGH  = 1;
  localparam int         BIT_GAIN_LOW     = 2;
  localparam int         BIT_GAIN_HIGH    = 3;
  localparam int         BIT_HYSTERESIS   = 0;
  localparam int         BIT_ACQUIRE      = 0;
  localparam int         BIT_LP_BYPASS    = 3;
  localparam logic [3:0] PAGE_RESET       = 4'h0;
  localparam int         AMP_W            = 8;
  localparam int         SHIFT_W          = 8;
endpackage : dct_pkg

// file: src/dct_sync.sv
// Purpose: two-flop synchroniser for one level
// Assumes: d is asynchronous to clk
// Notes:   first stage read only by second stage
`timescale 1ns/1ns
module dct_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // level
  input  wire logic d,
  output logic      q
);
  logic meta_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : dct_sync

// file: src/dct_demod_ctrl.sv
// Purpose: demodulator configuration pages and locked analog test mode
// Assumes: serial shift register, mode pin and amplitude are from outside
// Notes:   host-side search and recovery routines are not in hardware
//
// Notes on behaviour
// - acquire bit holds live amplitude as reference
// - after acquire, flag set if amplitude exceeds reference
// - test mode locked until one mode-pin pulse
// - unlocked 21h command drives comparator flag on pin
// - mode pin is unlock input and comparator flag output
// - test-off command releases the mode pin
// - reset clears test mode and re-locks it
// - page 0 bit1 highpass, bit0 lowpass select
// - filter combinations 10b and 01b also accepted
// - page 3 bit 3 bypasses primary lowpass
// - page 0 upper bits select gain 100..1000
// - page 1 hysteresis bit adds fixed threshold
`timescale 1ns/1ns
module dct_demod_ctrl (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       srst,
  // serial command interface, already framed
  input  wire logic                       sif_reset,
  input  wire logic                       cmd_valid,
  input  wire logic [dct_pkg::SHIFT_W-1:0] cmd_word,
  // demodulator analog side, sampled
  input  wire logic [dct_pkg::AMP_W-1:0]  amp_live,
  // mode pin, three signals, and the analog test value
  input  wire logic                       mode_in,
  output logic                            mode_out,
  output logic                            mode_oe_n,
  output logic [dct_pkg::AMP_W-1:0]       analog_test_value,
  // configuration outputs to the analog chain
  output logic                            lowpass_cutoff_select,
  output logic                            highpass_cutoff_select,
  output logic                            gain_select_low,
  output logic                            gain_select_high,
  output logic                            hysteresis_enable,
  output logic                            primary_lowpass_bypass,
  output logic                            acquire_amplitude_bit,
  // status
  output logic                            amplitude_greater_flag,
  output logic                            test_unlocked,
  output logic                            analog_test_active
);

  ////////////////////////////////////////////////////////////////////////////
  // mode pin synchroniser and rising/falling detect
  logic mode_s;
  logic mode_prev_q;
  logic mode_high_seen_q;

  dct_sync u_mode_sync (
    .clk  (clk),
    .srst (srst),
    .d    (mode_in),
    .q    (mode_s)
  );

  wire mode_rise = mode_s & ~mode_prev_q;
  wire mode_fall = ~mode_s & mode_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // command decode
  wire is_page_wr = cmd_valid & (cmd_word[7:6] == dct_pkg::CMD_PAGE_PREFIX);
  wire [1:0] page_sel = cmd_word[dct_pkg::PAGE_HI:dct_pkg::PAGE_LO];
  wire [3:0] page_data = cmd_word[3:0];
  wire wr_p0 = is_page_wr & (page_sel == dct_pkg::PAGE_GAIN_FILT);
  wire wr_p1 = is_page_wr & (page_sel == dct_pkg::PAGE_HYST);
  wire wr_p2 = is_page_wr & (page_sel == dct_pkg::PAGE_ACQ);
  wire wr_p3 = is_page_wr & (page_sel == dct_pkg::PAGE_LP_BYPASS);
  // interface reset qualifies every test command
  logic armed_q;
  wire is_anaout = cmd_valid & armed_q & (cmd_word == dct_pkg::CMD_ANALOG_TEST_OUTPUT_COMMAND);
  wire is_off    = cmd_valid & armed_q & (cmd_word == dct_pkg::CMD_TEST_OFF);

  ////////////////////////////////////////////////////////////////////////////
  // configuration pages, four bits each
  logic [3:0] page0_q;
  logic [3:0] page1_q;
  logic [3:0] page2_q;
  logic [3:0] page3_q;

  // one short process per page, so a write never touches a neighbour
  always_ff @(posedge clk) begin
    if (srst) begin
      page0_q <= dct_pkg::PAGE_RESET;
    end else if (wr_p0) begin
      page0_q <= page_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      page1_q <= dct_pkg::PAGE_RESET;
    end else if (wr_p1) begin
      page1_q <= page_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      page2_q <= dct_pkg::PAGE_RESET;
    end else if (wr_p2) begin
      page2_q <= page_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      page3_q <= dct_pkg::PAGE_RESET;
    end else if (wr_p3) begin
      page3_q <= page_data;
    end
  end

  // any of the four filter combinations passes straight to the switches
  assign lowpass_cutoff_select  = page0_q[dct_pkg::BIT_FILTER_LOW];
  assign highpass_cutoff_select = page0_q[dct_pkg::BIT_FILTER_HIGH];
  assign gain_select_low        = page0_q[dct_pkg::BIT_GAIN_LOW];
  assign gain_select_high       = page0_q[dct_pkg::BIT_GAIN_HIGH];
  assign hysteresis_enable      = page1_q[dct_pkg::BIT_HYSTERESIS];
  assign primary_lowpass_bypass = page3_q[dct_pkg::BIT_LP_BYPASS];
  assign acquire_amplitude_bit  = page2_q[dct_pkg::BIT_ACQUIRE];

  ////////////////////////////////////////////////////////////////////////////
  // amplitude reference and comparator
  logic [dct_pkg::AMP_W-1:0] amp_ref_q;
  logic                      cmp_q;

  wire amp_gt_ref = amp_live > amp_ref_q;

  // reference follows the live level while acquiring, then freezes
  always_ff @(posedge clk) begin
    if (srst) begin
      amp_ref_q <= '0;
    end else if (acquire_amplitude_bit) begin
      amp_ref_q <= amp_live;
    end
  end

  // flag held low while acquiring so a stale result never shows
  always_ff @(posedge clk) begin
    if (srst) begin
      cmp_q <= 1'b0;
    end else begin
      cmp_q <= ~acquire_amplitude_bit & amp_gt_ref;
    end
  end
  assign amplitude_greater_flag = cmp_q;

  ////////////////////////////////////////////////////////////////////////////
  // test-mode lock and analog output
  logic unlock_q;
  logic ana_q;
  logic [dct_pkg::AMP_W-1:0] ana_val_q;

  // pin edges are ignored while driving, our own output is not a pulse
  wire pulse_start = ~ana_q & mode_rise;
  wire pulse_end   = ~ana_q & mode_fall & mode_high_seen_q;
  wire ana_set     = is_anaout & unlock_q;
  wire ana_clr     = is_off;

  // pin edge tracking and the one-time unlock
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_prev_q      <= 1'b0;
      mode_high_seen_q <= 1'b0;
      unlock_q         <= 1'b0;
    end else begin
      mode_prev_q <= ana_q ? 1'b0 : mode_s;
      if (pulse_start) mode_high_seen_q <= 1'b1;
      if (pulse_end) unlock_q <= 1'b1;
    end
  end

  // interface reset arms exactly one following command; set wins
  always_ff @(posedge clk) begin
    if (srst) begin
      armed_q <= 1'b0;
    end else begin
      if (sif_reset) armed_q <= 1'b1;
      else if (cmd_valid) armed_q <= 1'b0;
    end
  end

  // set and clear cannot meet: the two command codes differ
  always_ff @(posedge clk) begin
    if (srst) begin
      ana_q <= 1'b0;
    end else begin
      if (ana_set) ana_q <= 1'b1;
      else if (ana_clr) ana_q <= 1'b0;
    end
  end

  // sampled code of the live level, zero outside test mode
  always_ff @(posedge clk) begin
    if (srst) begin
      ana_val_q <= '0;
    end else begin
      ana_val_q <= ana_q ? amp_live : '0;
    end
  end

  // analog level leaves as a sampled code, pin driven only in test mode
  assign mode_oe_n          = ~ana_q;
  assign mode_out           = ana_q & cmp_q;
  assign analog_test_value  = ana_val_q;
  assign test_unlocked      = unlock_q;
  assign analog_test_active = ana_q;

endmodule : dct_demod_ctrl

// file: verification/dct_demod_checker.sv
// Purpose: port assertions for dct_demod_ctrl
// Assumes: commands follow an interface reset
// Notes:   reset check keeps its own disable
`timescale 1ns/1ns
module dct_chk (
  // clock and reset
  input wire logic                        clk,
  input wire logic                        srst,
  // commands
  input wire logic                        sif_reset,
  input wire logic                        cmd_valid,
  input wire logic [dct_pkg::SHIFT_W-1:0] cmd_word,
  // outputs
  input wire logic                        gain_select_high,
  input wire logic                        lowpass_cutoff_select,
  input wire logic                        hysteresis_enable,
  input wire logic                        primary_lowpass_bypass,
  input wire logic                        mode_oe_n,
  input wire logic                        test_unlocked,
  input wire logic                        analog_test_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire logic       pw = cmd_valid && cmd_word[7:6] == dct_pkg::CMD_PAGE_PREFIX;
  wire logic [1:0] pg = cmd_word[5:4];
  sequence s_cmd(logic [7:0] c);
    sif_reset ##1 cmd_valid && cmd_word == c;
  endsequence
  ////////////////////////////////
  chk_gain_bit: assert property (pw && pg == 2'h0 |=> gain_select_high == $past(cmd_word[3]))
    else $error("gain bit wrong");
  chk_lowpass_bit: assert property (pw && pg == 2'h0 |=> lowpass_cutoff_select == $past(cmd_word[0]))
    else $error("lowpass bit wrong");
  chk_hyst_bit: assert property (pw && pg == 2'h1 |=> hysteresis_enable == $past(cmd_word[0]))
    else $error("hysteresis bit wrong");
  chk_bypass_bit: assert property (pw && pg == 2'h3 |=> primary_lowpass_bypass == $past(cmd_word[3]))
    else $error("bypass bit wrong");
  chk_test_on: assert property (s_cmd(dct_pkg::CMD_ANALOG_TEST_OUTPUT_COMMAND) ##0 test_unlocked |=> analog_test_active)
    else $error("test mode not entered");
  chk_test_lock: assert property (!test_unlocked && !analog_test_active |=> !analog_test_active)
    else $error("locked test mode entered");
  chk_test_off: assert property (s_cmd(dct_pkg::CMD_TEST_OFF) |=> !analog_test_active && mode_oe_n)
    else $error("test mode not left");
  chk_pin_drive: assert property (mode_oe_n != analog_test_active)
    else $error("pin drive mismatch");
  chk_reset_lock: assert property (disable iff (1'b0) srst |=> !test_unlocked && !analog_test_active)
    else $error("reset left test mode");
endmodule : dct_chk
bind dct_demod_ctrl dct_chk dct_chk_i (.clk, .srst, .sif_reset, .cmd_valid, .cmd_word, .gain_select_high,
  .lowpass_cutoff_select, .hysteresis_enable, .primary_lowpass_bypass, .mode_oe_n, .test_unlocked,
  .analog_test_active);

// file: verification/dct_host_model.sv
// Purpose: host controller on the command side
// Assumes: one command per interface reset
// Notes:   idle word shows the inverse of the last one
`timescale 1ns/1ns
module dct_host_model (
  // clock
  input wire logic                    clk,
  // commands
  output logic                        sif_reset,
  output logic                        cmd_valid,
  output logic [dct_pkg::SHIFT_W-1:0] cmd_word
);
  localparam int SETTLE_CYCLES = 8;
  // sampling time: twice the antenna time plus offset, kept to six bits
  function automatic logic [5:0] sampling_time(input logic [7:0] t_ant, input logic [5:0] t_oc);
    logic [8:0] sum;
    sum = {t_ant, 1'b0} + {3'b000, t_oc};
    return sum[5:0];
  endfunction : sampling_time
  // backup after two misreads: a quarter turn either way
  function automatic logic [5:0] backup_time(input logic [5:0] ts, input logic up);
    return up ? ts + 6'h10 : ts - 6'h10;
  endfunction : backup_time
  // k-th offset of the search window, one step is 5.625 degrees
  function automatic logic [5:0] window_const(input int k);
    return 6'h37 + k[5:0];
  endfunction : window_const
  // demodulator settling after any phase change
  task automatic settle;
    repeat (SETTLE_CYCLES) @(posedge clk);
    #1;
  endtask : settle
  initial begin
    sif_reset = 1'b0;
    cmd_valid = 1'b0;
    cmd_word  = 8'h00;
  end
  task automatic send(input logic [7:0] w);
    @(posedge clk);
    #1 sif_reset = 1'b1;
    @(posedge clk);
    #1 sif_reset = 1'b0;
    cmd_valid = 1'b1;
    cmd_word  = w;
    @(posedge clk);
    #1 cmd_valid = 1'b0;
    cmd_word  = ~w;
  endtask : send
endmodule : dct_host_model

// file: verification/dct_demod_ctrl_tb_top.sv
// Purpose: self-checking bench for dct_demod_ctrl
// Assumes: inputs move 1 ns after the edge
// Notes:   page rows first, then acquire and test mode
`timescale 1ns/1ns
module dct_demod_ctrl_tb_top;
  logic        clk;
  logic        srst;
  logic        sif_reset;
  logic        cmd_valid;
  logic [7:0]  cmd_word;
  logic [7:0]  amp;
  logic        mode_sw;
  logic        mode_out;
  logic        mode_oe_n;
  logic [7:0]  ana;
  logic [5:0]  cfg;
  logic        acq;
  logic        flag;
  logic        unl;
  logic        act;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  logic [5:0]  best;
  logic [5:0]  ts;
  logic [7:0]  volts [3] = '{8'h30, 8'h52, 8'h41};
  // pulled-down pin: switch only, unless the block drives it
  wire logic   mode_pin = mode_oe_n ? mode_sw : mode_out;
  logic [13:0] rows [9] = '{{8'h4B, 6'h2C}, {8'h42, 6'h08}, {8'h55, 6'h0A}, {8'h38, 6'h0A}, {8'h78, 6'h0B},
                            {8'h4D, 6'h37}, {8'h50, 6'h35}, {8'h74, 6'h34}, {8'h47, 6'h1C}};
  dct_host_model dct_host_model_i (.clk(clk), .sif_reset(sif_reset), .cmd_valid(cmd_valid), .cmd_word(cmd_word));
  dct_demod_ctrl dct_demod_ctrl_i (.clk(clk), .srst(srst), .sif_reset(sif_reset), .cmd_valid(cmd_valid),
    .cmd_word(cmd_word), .amp_live(amp), .mode_in(mode_pin), .mode_out(mode_out), .mode_oe_n(mode_oe_n),
    .analog_test_value(ana), .gain_select_high(cfg[5]), .gain_select_low(cfg[4]), .highpass_cutoff_select(cfg[3]),
    .lowpass_cutoff_select(cfg[2]), .hysteresis_enable(cfg[1]), .primary_lowpass_bypass(cfg[0]),
    .acquire_amplitude_bit(acq), .amplitude_greater_flag(flag), .test_unlocked(unl), .analog_test_active(act));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic complete_run;
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  ////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      num_errors++;
      complete_run();
    end
  end
  initial begin
    srst = 1'b1;
    amp = 8'h40;
    mode_sw = 1'b0;
    tick(5);
    srst = 1'b0;
    check({cfg, unl, act}, 8'h00);
    foreach (rows[i]) begin
      dct_host_model_i.send(rows[i][13:6]);
      tick(1);
      check(cfg, rows[i][5:0]);
    end
    // reference must follow the amplitude while acquiring
    dct_host_model_i.send(8'h61);
    amp = 8'h44;
    tick(2);
    check(acq, 8'h01);
    dct_host_model_i.send(8'h60);
    amp = 8'h45;
    tick(2);
    check(flag, 8'h01);
    amp = 8'h44;
    tick(2);
    check(flag, 8'h00);
    dct_host_model_i.send(dct_pkg::CMD_ANALOG_TEST_OUTPUT_COMMAND);
    tick(1);
    check(act, 8'h00);
    mode_sw = 1'b1;
    tick(4);
    mode_sw = 1'b0;
    tick(6);
    check(unl, 8'h01);
    dct_host_model_i.send(dct_pkg::CMD_ANALOG_TEST_OUTPUT_COMMAND);
    tick(2);
    check({act, mode_oe_n, mode_pin}, 8'h04);
    check(ana, amp);
    amp = 8'h46;
    tick(1);
    check(mode_pin, 8'h01);
    amp = 8'h44;
    tick(1);
    dct_host_model_i.send(dct_pkg::CMD_TEST_OFF);
    tick(1);
    check({act, mode_oe_n}, 8'h01);
    // fast search: three offsets, comparator keeps the larger voltage
    best = dct_host_model_i.window_const(0);
    amp = volts[0];
    dct_host_model_i.send(8'h61);
    dct_host_model_i.send(8'h60);
    for (int k = 1; k < 3; k++) begin
      amp = volts[k];
      tick(2);
      if (flag === 1'b1) begin
        best = dct_host_model_i.window_const(8 * k);
        dct_host_model_i.send(8'h61);
        dct_host_model_i.send(8'h60);
      end
    end
    check(best, 8'h3F);
    dct_host_model_i.settle();
    ts = dct_host_model_i.sampling_time(8'h13, best);
    check(ts, 8'h25);
    check(dct_host_model_i.backup_time(ts, 1'b1), 8'h35);
    check(dct_host_model_i.backup_time(ts, 1'b0), 8'h15);
    check(dct_host_model_i.window_const(16), 8'h07);
    srst = 1'b1;
    tick(1);
    srst = 1'b0;
    dct_host_model_i.send(dct_pkg::CMD_ANALOG_TEST_OUTPUT_COMMAND);
    tick(1);
    check({act, unl}, 8'h00);
    complete_run();
  end
endmodule : dct_demod_ctrl_tb_top
